// ===== design/pmu_pkg.sv
package pmu_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses, one word apart, on the plain register port)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_PMODE = 8'h00;
  localparam logic [7:0] ADDR_START_EN = 8'h04;
  localparam logic [7:0] ADDR_START_STAT = 8'h08;
  localparam logic [7:0] ADDR_BROWNOUT_CFG = 8'h0C;
  localparam logic [7:0] ADDR_BROWNOUT_STAT = 8'h10;
  localparam logic [7:0] ADDR_RESET_STAT = 8'h14;
  localparam logic [7:0] ADDR_BOOT_STAT = 8'h18;
  localparam logic [7:0] ADDR_PROT_WORD = 8'h1C;

  // ----------------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------------
  localparam int START_PINS = 13;
  localparam int PMODE_GO_BIT = 2;
  localparam int PMODE_KEEP_WDOSC_BIT = 3;
  localparam int PMODE_KEEP_BROWNOUT_BIT = 4;
  localparam int BO_IRQ_LVL_LSB = 0;
  localparam int BO_RST_LVL_LSB = 2;
  localparam int BO_RST_EN_BIT = 4;
  localparam int RST_SRC_PIN = 0;
  localparam int RST_SRC_WDT = 1;
  localparam int RST_SRC_POR = 2;
  localparam int RST_SRC_BROWNOUT = 3;

  // ----------------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
  localparam logic [12:0] START_EN_RESET = 13'h0000;
  localparam logic [4:0] BROWNOUT_CFG_RESET = 5'h00;
  localparam logic [3:0] RESET_STAT_RESET = 4'h4;
  localparam logic [31:0] PROT_PATTERN_ONE = 32'h1234_5678;
  localparam logic [31:0] PROT_PATTERN_TWO = 32'h8765_4321;
  localparam logic [31:0] PROT_PATTERN_THREE = 32'h4321_8765;
  localparam logic [31:0] PROT_PATTERN_NO_ISP = 32'h4E69_7370;
  localparam logic [31:0] BOOT_VECTOR_ADDR = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int INTERNAL_RC_OSC_HZ = 12_000_000;
  localparam int RST_STRETCH_CYCLES = 4;
  localparam int RST_CNT_W = 3;

  typedef enum logic [1:0] {
    PM_RUN_SLEEP_REQ = 2'h0,
    PM_SLEEP = 2'h1,
    PM_DEEP_SLEEP = 2'h2,
    PM_DEEP_PD = 2'h3
  } pmode_sel_t;

  typedef enum logic [1:0] {
    PROT_NONE,
    PROT_LEVEL_ONE,
    PROT_LEVEL_TWO,
    PROT_LEVEL_THREE
  } prot_level_t;

endpackage : pmu_pkg

// ===== design/reset_collect.sv
// reset combiner: any active source holds chip reset, release is stretched
// and then synchronous to the core_clk_i clock of this block
module reset_collect (
  // clock and raw reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // sources, already synchronised, active high
  input wire logic [3:0] src_i,
  // combined reset
  output logic chip_rst_o,
  output logic release_o
);

  logic [pmu_pkg::RST_CNT_W-1:0] hold_cnt;
  localparam int CNT_LAST = pmu_pkg::RST_STRETCH_CYCLES - 1;
  logic held;
  wire any_src = |src_i;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_cnt <= '0;
      held <= 1'b1;
    end else if (any_src) begin
      hold_cnt <= '0;
      held <= 1'b1;
    end else if (held) begin
      hold_cnt <= hold_cnt + 1'b1;
      if (hold_cnt == CNT_LAST[pmu_pkg::RST_CNT_W-1:0]) held <= 1'b0;
    end
  end

  // asserting is immediate, release only on a clock edge
  assign chip_rst_o = held | any_src;
  assign release_o = ~held;

endmodule : reset_collect

// ===== design/power_mode_reset_boot_ctrl.sv
// ------------------------------------------------------------------------
// power, wake, reset and boot control
// ------------------------------------------------------------------------
// Functional notes
// - sleep gates the core clock only
// - sleep ends on reset or interrupt
// - deep-sleep also stops analog, optional keeps
// - start detection works without running clock; here start pins are sampled through two flops on core_clk_i
// - deep power-down keeps only wake pin
// - each start pin has own interrupt line
// - four reset sources assert chip reset
// - reset starts RC oscillator, flash init
// - registers preset, fetch from address zero
// - four brownout interrupt thresholds selectable
// - brownout level readable in status register
// - four further brownout reset thresholds
// - low request pin at reset selects programming
// - select pin high UART, low CAN
// - protection pattern in flash, app programming kept
// - level one: no debug, sector zero kept
// - level two: no debug, full erase only
// - level three: no debug, no programming
// - pin programming entry disableable on its own
// - run from 12 MHz RC after power-up
//
// Local design decisions: the address map and strobed register access.
module power_mode_reset_boot_ctrl (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // processor side
  input wire logic sleep_req_i,
  input wire logic irq_pending_i,
  output logic core_clk_en_o,
  output logic [31:0] fetch_addr_o,
  // pins
  input wire logic [12:0] start_pin_i,
  input wire logic reset_pin_b_i,
  input wire logic deep_power_down_wake_pin_b_i,
  input wire logic prog_request_pin_i,
  input wire logic boot_iface_select_pin_i,
  // other reset sources and analog monitors
  input wire logic wdt_reset_i,
  input wire logic por_i,
  input wire logic [3:0] brownout_below_i,
  // flash protection word read at boot
  input wire logic [31:0] prot_word_i,
  // interrupt lines
  output logic [12:0] start_irq_o,
  output logic brownout_irq_o,
  // power and clock controls
  output logic analog_pwr_en_o,
  output logic wdog_osc_en_o,
  output logic brownout_detector_en_o,
  output logic core_pwr_en_o,
  output logic internal_rc_osc_en_o,
  output logic internal_rc_osc_sel_o,
  output logic flash_init_o,
  output logic chip_rst_o,
  // boot decisions
  output logic boot_isp_o,
  output logic boot_uart_o,
  output logic debug_en_o,
  output logic isp_allowed_o,
  output logic isp_sector0_lock_o,
  output logic isp_full_erase_only_o,
  output logic iap_allowed_o
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [12:0] start_s1, start_s2;
  logic [3:0] misc_s1, misc_s2;
  logic [3:0] bo_s1, bo_s2;
  logic [1:0] src_s1, src_s2;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_s1 <= '0;
      start_s2 <= '0;
      // straps and reset pins idle high, so reset shows no false request
      misc_s1 <= 4'hF;
      misc_s2 <= 4'hF;
      bo_s1 <= '0;
      bo_s2 <= '0;
      src_s1 <= '0;
      src_s2 <= '0;
    end else begin
      start_s1 <= start_pin_i;
      start_s2 <= start_s1;
      misc_s1 <= {reset_pin_b_i, deep_power_down_wake_pin_b_i, prog_request_pin_i,
                  boot_iface_select_pin_i};
      misc_s2 <= misc_s1;
      bo_s1 <= brownout_below_i;
      bo_s2 <= bo_s1;
      src_s1 <= {wdt_reset_i, por_i};
      src_s2 <= src_s1;
    end
  end

  wire reset_pin_b = misc_s2[3];
  wire wake_pin_b = misc_s2[2];
  wire prog_req = misc_s2[1];
  wire iface_sel = misc_s2[0];

  // ----------------------------------------------------------------------
  // reset combining
  // ----------------------------------------------------------------------
  logic [1:0] bo_irq_lvl, bo_rst_lvl;
  logic bo_rst_en;
  logic dpd_active;
  logic dpd_wake;
  logic [3:0] rst_src;
  logic chip_rst, rst_release, rst_release_d;

  wire bo_irq_level = bo_s2[bo_irq_lvl];
  wire bo_rst_level = bo_rst_en & bo_s2[bo_rst_lvl];

  assign rst_src[pmu_pkg::RST_SRC_PIN] = ~reset_pin_b | dpd_wake;
  assign rst_src[pmu_pkg::RST_SRC_WDT] = src_s2[1];
  assign rst_src[pmu_pkg::RST_SRC_POR] = src_s2[0];
  assign rst_src[pmu_pkg::RST_SRC_BROWNOUT] = bo_rst_level;

  reset_collect u_reset_collect (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .src_i(rst_src),
    .chip_rst_o(chip_rst),
    .release_o(rst_release)
  );

  wire rst_rise = rst_release & ~rst_release_d;

  // ----------------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------------
  function automatic logic wr_at(input logic strobe, input logic [7:0] addr,
                                 input logic [7:0] target);
    return strobe && addr == target;
  endfunction : wr_at

  // writes during chip reset are dropped by the register block itself
  wire wr_pmode = wr_at(reg_wr_i, reg_addr_i, pmu_pkg::ADDR_PMODE);
  wire wr_start_en = wr_at(reg_wr_i, reg_addr_i, pmu_pkg::ADDR_START_EN);
  wire wr_start_stat = wr_at(reg_wr_i, reg_addr_i, pmu_pkg::ADDR_START_STAT);
  wire wr_bo_cfg = wr_at(reg_wr_i, reg_addr_i, pmu_pkg::ADDR_BROWNOUT_CFG);
  wire wr_rst_stat = wr_at(reg_wr_i, reg_addr_i, pmu_pkg::ADDR_RESET_STAT);

  // ----------------------------------------------------------------------
  // power mode state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_DEEP_SLEEP, ST_DEEP_PD} pstate_t;
  pstate_t state, next_state;
  logic [1:0] pmode_sel;
  logic keep_wdosc, keep_bo;
  logic [12:0] start_en, start_stat;

  // start detection is a level compare after two flops on the clock of
  // this block, which keeps running while the core clock is stopped
  wire [12:0] start_hit = start_s2 & start_en;
  wire any_start = |start_hit;
  wire go_wr = wr_pmode && reg_wdata_i[pmu_pkg::PMODE_GO_BIT];
  // a go write carries its own mode, the stored one is still the old value
  wire [1:0] mode_req = go_wr ? reg_wdata_i[1:0] : pmode_sel;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (sleep_req_i || go_wr) begin
          unique case (mode_req)
            pmu_pkg::PM_DEEP_SLEEP: next_state = ST_DEEP_SLEEP;
            pmu_pkg::PM_DEEP_PD: next_state = ST_DEEP_PD;
            default: next_state = ST_SLEEP;
          endcase
        end
      end
      ST_SLEEP: if (irq_pending_i) next_state = ST_RUN;
      ST_DEEP_SLEEP: if (any_start || irq_pending_i) next_state = ST_RUN;
      ST_DEEP_PD: if (!wake_pin_b) next_state = ST_RUN;
    endcase
  end

  assign dpd_active = state == ST_DEEP_PD;
  assign dpd_wake = dpd_active & ~wake_pin_b;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_RUN;
      rst_release_d <= 1'b0;
    end else begin
      rst_release_d <= rst_release;
      state <= chip_rst ? ST_RUN : next_state;
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  logic [3:0] rst_stat;
  logic [31:0] prot_word;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pmode_sel <= '0;
      keep_wdosc <= 1'b0;
      keep_bo <= 1'b0;
      start_en <= pmu_pkg::START_EN_RESET;
      start_stat <= '0;
      {bo_rst_en, bo_rst_lvl, bo_irq_lvl} <= pmu_pkg::BROWNOUT_CFG_RESET;
      rst_stat <= pmu_pkg::RESET_STAT_RESET;
    end else if (chip_rst) begin
      // preset everything but the reset status while reset holds
      pmode_sel <= '0;
      keep_wdosc <= 1'b0;
      keep_bo <= 1'b0;
      start_en <= pmu_pkg::START_EN_RESET;
      start_stat <= '0;
      {bo_rst_en, bo_rst_lvl, bo_irq_lvl} <= pmu_pkg::BROWNOUT_CFG_RESET;
      // sources only log while reset holds, so a clear never races them
      rst_stat <= rst_stat | rst_src;
    end else begin
      if (wr_pmode) begin
        pmode_sel <= reg_wdata_i[1:0];
        keep_wdosc <= reg_wdata_i[pmu_pkg::PMODE_KEEP_WDOSC_BIT];
        keep_bo <= reg_wdata_i[pmu_pkg::PMODE_KEEP_BROWNOUT_BIT];
      end
      if (wr_start_en) start_en <= reg_wdata_i[12:0];
      if (wr_bo_cfg) begin
        bo_irq_lvl <= reg_wdata_i[pmu_pkg::BO_IRQ_LVL_LSB +: 2];
        bo_rst_lvl <= reg_wdata_i[pmu_pkg::BO_RST_LVL_LSB +: 2];
        bo_rst_en <= reg_wdata_i[pmu_pkg::BO_RST_EN_BIT];
      end
      // write one clears; a hit in the same cycle wins
      if (wr_start_stat) begin
        start_stat <= (start_stat & ~reg_wdata_i[12:0]) | start_hit;
      end else begin
        start_stat <= start_stat | start_hit;
      end
      if (wr_rst_stat) begin
        rst_stat <= rst_stat & ~reg_wdata_i[3:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // boot straps and protection, caught once at reset release
  // ----------------------------------------------------------------------
  logic strap_prog_low, strap_uart;
  logic [1:0] prot_lvl;
  logic isp_pin_off;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_prog_low <= 1'b0;
      strap_uart <= 1'b1;
      prot_lvl <= pmu_pkg::PROT_NONE;
      isp_pin_off <= 1'b0;
      prot_word <= '0;
    end else if (rst_rise) begin
      strap_prog_low <= ~prog_req;
      strap_uart <= iface_sel;
      prot_word <= prot_word_i;
      unique case (prot_word_i)
        pmu_pkg::PROT_PATTERN_ONE: prot_lvl <= pmu_pkg::PROT_LEVEL_ONE;
        pmu_pkg::PROT_PATTERN_TWO: prot_lvl <= pmu_pkg::PROT_LEVEL_TWO;
        pmu_pkg::PROT_PATTERN_THREE: prot_lvl <= pmu_pkg::PROT_LEVEL_THREE;
        default: prot_lvl <= pmu_pkg::PROT_NONE;
      endcase
      isp_pin_off <= prot_word_i == pmu_pkg::PROT_PATTERN_NO_ISP;
    end
  end

  wire lvl3 = prot_lvl == pmu_pkg::PROT_LEVEL_THREE;

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  wire in_deep = state == ST_DEEP_SLEEP || state == ST_DEEP_PD;

  assign core_clk_en_o = state == ST_RUN && !chip_rst;
  assign analog_pwr_en_o = !in_deep;
  assign wdog_osc_en_o = !in_deep || (state == ST_DEEP_SLEEP && keep_wdosc);
  assign brownout_detector_en_o = !in_deep || (state == ST_DEEP_SLEEP && keep_bo);
  assign core_pwr_en_o = !dpd_active;
  assign internal_rc_osc_en_o = chip_rst || !in_deep;
  assign internal_rc_osc_sel_o = 1'b1;
  assign flash_init_o = chip_rst;
  assign chip_rst_o = chip_rst;
  assign fetch_addr_o = pmu_pkg::BOOT_VECTOR_ADDR;
  assign start_irq_o = start_stat;
  assign brownout_irq_o = bo_irq_level;
  assign boot_isp_o = strap_prog_low && !isp_pin_off && !lvl3;
  assign boot_uart_o = strap_uart;
  assign debug_en_o = prot_lvl == pmu_pkg::PROT_NONE;
  assign isp_allowed_o = !lvl3;
  assign isp_sector0_lock_o = prot_lvl == pmu_pkg::PROT_LEVEL_ONE;
  assign isp_full_erase_only_o = prot_lvl == pmu_pkg::PROT_LEVEL_TWO;
  assign iap_allowed_o = 1'b1;

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    unique case (reg_addr_i)
      pmu_pkg::ADDR_PMODE: next_rdata = {27'h0, keep_bo, keep_wdosc, 1'b0, pmode_sel};
      pmu_pkg::ADDR_START_EN: next_rdata = {19'h0, start_en};
      pmu_pkg::ADDR_START_STAT: next_rdata = {19'h0, start_stat};
      pmu_pkg::ADDR_BROWNOUT_CFG: next_rdata = {27'h0, bo_rst_en, bo_rst_lvl, bo_irq_lvl};
      pmu_pkg::ADDR_BROWNOUT_STAT: next_rdata = {27'h0, bo_irq_level, bo_s2};
      pmu_pkg::ADDR_RESET_STAT: next_rdata = {28'h0, rst_stat};
      pmu_pkg::ADDR_BOOT_STAT: next_rdata = {26'h0, isp_pin_off, prot_lvl, strap_uart,
                                             strap_prog_low, boot_isp_o};
      pmu_pkg::ADDR_PROT_WORD: next_rdata = prot_word;
      default: next_rdata = pmu_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    // data stand one cycle only, so a late sampler sees zero, not stale data
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule : power_mode_reset_boot_ctrl

// ===== sim/pmu_monitor.sv
// ----
// power, reset and boot checks
// ----
module pmu_monitor (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // reset sources and monitors
  input wire logic reset_pin_b_i,
  input wire logic wdt_reset_i,
  input wire logic por_i,
  input wire logic [3:0] brownout_below_i,
  // observed outputs
  input wire logic brownout_irq_o,
  input wire logic core_clk_en_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic analog_pwr_en_o,
  input wire logic core_pwr_en_o,
  input wire logic internal_rc_osc_en_o,
  input wire logic flash_init_o,
  input wire logic chip_rst_o,
  input wire logic boot_isp_o,
  input wire logic debug_en_o,
  input wire logic isp_allowed_o,
  input wire logic isp_sector0_lock_o,
  input wire logic isp_full_erase_only_o,
  input wire logic iap_allowed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_gate_in_reset: assert property (chip_rst_o |-> !core_clk_en_o)
    else $error("core clock runs during chip reset");
  a_flash_init_rst: assert property (flash_init_o == chip_rst_o)
    else $error("flash init not tied to chip reset");
  a_rc_in_reset: assert property (chip_rst_o |-> internal_rc_osc_en_o)
    else $error("rc oscillator off during chip reset");
  a_fetch_zero: assert property (fetch_addr_o == pmu_pkg::BOOT_VECTOR_ADDR)
    else $error("fetch address not zero");
  a_pin_reset: assert property (!reset_pin_b_i [*3] |-> ##[0:4] chip_rst_o)
    else $error("reset pin ignored");
  a_wdt_reset: assert property (wdt_reset_i [*3] |-> ##[0:4] chip_rst_o)
    else $error("watchdog reset ignored");
  a_release_clean: assert property ($fell(chip_rst_o) |->
    $past(reset_pin_b_i, 4) && !$past(wdt_reset_i, 4) && !$past(por_i, 4))
    else $error("chip reset released while a source was active");
  a_iap_always: assert property (iap_allowed_o)
    else $error("app programming blocked");
  a_prot_no_isp: assert property (!isp_allowed_o |-> !boot_isp_o)
    else $error("pin programming entry despite blocked isp");
  a_prot_debug: assert property (debug_en_o |->
    !isp_sector0_lock_o && !isp_full_erase_only_o)
    else $error("isp restriction without protection");
  a_analog_asleep: assert property (!analog_pwr_en_o |-> !core_clk_en_o)
    else $error("analog off while core runs");
  a_pd_all_off: assert property (!core_pwr_en_o |->
    !analog_pwr_en_o && !core_clk_en_o)
    else $error("power-down leaves logic powered");
  a_bo_irq_cause: assert property (brownout_irq_o |->
    (|$past(brownout_below_i, 1)) || (|$past(brownout_below_i, 2)) ||
    (|$past(brownout_below_i, 3)))
    else $error("brownout irq with no low supply");
endmodule : pmu_monitor

bind power_mode_reset_boot_ctrl pmu_monitor pmu_monitor_i (.core_clk_i, .rst_b_i,
  .reset_pin_b_i, .wdt_reset_i, .por_i, .brownout_below_i, .brownout_irq_o,
  .core_clk_en_o, .fetch_addr_o, .analog_pwr_en_o, .core_pwr_en_o, .internal_rc_osc_en_o,
  .flash_init_o, .chip_rst_o, .boot_isp_o, .debug_en_o, .isp_allowed_o,
  .isp_sector0_lock_o, .isp_full_erase_only_o, .iap_allowed_o);

// ===== sim/core_model.sv
// ----
// processor and interrupt controller stand-in
// ----
module core_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // from block and bench
  input wire logic [12:0] start_irq_i,
  input wire logic [12:0] irq_mask_i,
  input wire logic sleep_cmd_i,
  // to block
  output logic sleep_req_o,
  output logic irq_pending_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sleep_cmd_q;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sleep_req_o <= 1'h0;
      irq_pending_o <= 1'h0;
      sleep_cmd_q <= 1'h0;
    end else begin
      // clock source assumed already on rc before any sleep
      // one request per command, like a single wait-for-interrupt
      sleep_cmd_q <= sleep_cmd_i;
      sleep_req_o <= sleep_cmd_i && !sleep_cmd_q;
      // a line counts only once software enabled it here
      irq_pending_o <= |(start_irq_i & irq_mask_i);
    end
  end
endmodule : core_model

// ===== sim/tb.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 300) begin \
  @(posedge core_clk_i); n++; end #1; end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'h0, rst_b_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0, sleep_cmd = 1'h0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000, prot_word_i = 32'h0000_0000, rd_val;
  logic [12:0] start_pin_i = 13'h0000, irq_mask = 13'h0000, start_irq_o;
  logic reset_pin_b_i = 1'h1, deep_power_down_wake_pin_b_i = 1'h1, prog_request_pin_i = 1'h0;
  logic boot_iface_select_pin_i = 1'h1, wdt_reset_i = 1'h0, por_i = 1'h0;
  logic [3:0] brownout_below_i = 4'h0;
  logic sleep_req_i, irq_pending_i, core_clk_en_o, brownout_irq_o, analog_pwr_en_o;
  logic wdog_osc_en_o, brownout_detector_en_o, core_pwr_en_o, internal_rc_osc_en_o;
  logic internal_rc_osc_sel_o, flash_init_o, chip_rst_o, boot_isp_o, boot_uart_o;
  logic debug_en_o, isp_allowed_o, isp_sector0_lock_o, isp_full_erase_only_o, iap_allowed_o;
  logic [31:0] reg_rdata_o, fetch_addr_o;
  int fails = 0, check_count = 0, cyc = 0, n;
  // blank flash, level one, two, three, pin entry off, blank with pin high
  logic [31:0] pw[6] = '{32'hFFFF_FFFF, pmu_pkg::PROT_PATTERN_ONE, pmu_pkg::PROT_PATTERN_TWO,
    pmu_pkg::PROT_PATTERN_THREE, pmu_pkg::PROT_PATTERN_NO_ISP, 32'hFFFF_FFFF};
  logic [4:0] ex[6] = '{5'h19, 5'h0D, 5'h0B, 5'h00, 5'h10, 5'h00};
  logic [4:0] mk[6] = '{5'h1F, 5'h1F, 5'h1B, 5'h19, 5'h11, 5'h01};

  power_mode_reset_boot_ctrl power_mode_reset_boot_ctrl_i (.core_clk_i, .rst_b_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sleep_req_i,
    .irq_pending_i, .core_clk_en_o, .fetch_addr_o, .start_pin_i, .reset_pin_b_i,
    .deep_power_down_wake_pin_b_i, .prog_request_pin_i, .boot_iface_select_pin_i,
    .wdt_reset_i, .por_i, .brownout_below_i, .prot_word_i, .start_irq_o, .brownout_irq_o,
    .analog_pwr_en_o, .wdog_osc_en_o, .brownout_detector_en_o, .core_pwr_en_o,
    .internal_rc_osc_en_o, .internal_rc_osc_sel_o, .flash_init_o, .chip_rst_o, .boot_isp_o,
    .boot_uart_o, .debug_en_o, .isp_allowed_o, .isp_sector0_lock_o, .isp_full_erase_only_o,
    .iap_allowed_o);
  core_model core_model_i (.core_clk_i, .rst_b_i, .start_irq_i(start_irq_o),
    .irq_mask_i(irq_mask), .sleep_cmd_i(sleep_cmd), .sleep_req_o(sleep_req_i),
    .irq_pending_o(irq_pending_i));

  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'h0;
    #1;
    rd_val = reg_rdata_o;
  endtask : rd

  task automatic pulse_pin(input int k);
    @(posedge core_clk_i);
    start_pin_i[k] <= 1'h1;
    repeat (4) @(posedge core_clk_i);
    start_pin_i[k] <= 1'h0;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : pulse_pin

  task automatic do_reset(input logic p, input logic s, input logic [31:0] w);
    @(posedge core_clk_i);
    rst_b_i <= 1'h0;
    prog_request_pin_i <= p;
    boot_iface_select_pin_i <= s;
    prot_word_i <= w;
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'h1;
    `WAITC(chip_rst_o === 1'h0)
  endtask : do_reset

  task automatic set_src(input logic [2:0] s);
    @(posedge core_clk_i);
    reset_pin_b_i <= !s[0];
    wdt_reset_i <= s[1];
    por_i <= s[2];
  endtask : set_src

  task automatic t_boot;
    logic [4:0] got;
    for (int i = 0; i < 6; i++) begin
      do_reset(logic'(i == 5), i[0], pw[i]);
      got = {debug_en_o, isp_allowed_o, isp_sector0_lock_o, isp_full_erase_only_o, boot_isp_o};
      `CHK(got & mk[i], ex[i] & mk[i])
      `CHK(boot_uart_o, i[0])
    end
    `CHK(internal_rc_osc_sel_o, 1'h1)
    rd(pmu_pkg::ADDR_START_EN);
    `CHK(rd_val[12:0], pmu_pkg::START_EN_RESET)
    rd(8'h40);
    `CHK(rd_val, pmu_pkg::READ_UNMAPPED)
  endtask : t_boot

  task automatic t_src;
    for (int k = 0; k < 3; k++) begin
      set_src(3'(1 << k));
      `WAITC(chip_rst_o === 1'h1)
      `CHK(chip_rst_o, 1'h1)
      `CHK({flash_init_o, internal_rc_osc_en_o}, 2'h3)
      set_src(3'h0);
      `WAITC(chip_rst_o === 1'h0)
      rd(pmu_pkg::ADDR_RESET_STAT);
      `CHK(rd_val[k], 1'h1)
      wr(pmu_pkg::ADDR_RESET_STAT, 32'h0000_000F);
    end
    set_src(3'h3);
    repeat (6) @(posedge core_clk_i);
    set_src(3'h2);
    repeat (12) @(posedge core_clk_i);
    #1;
    `CHK(chip_rst_o, 1'h1)
    set_src(3'h0);
    `WAITC(chip_rst_o === 1'h0)
    `CHK(chip_rst_o, 1'h0)
  endtask : t_src

  task automatic t_sleep;
    wr(pmu_pkg::ADDR_START_EN, 32'h0000_1FFF);
    wr(pmu_pkg::ADDR_PMODE, 32'h0000_0001);
    sleep_cmd <= 1'h1;
    `WAITC(core_clk_en_o === 1'h0)
    `CHK({core_clk_en_o, analog_pwr_en_o}, 2'h1)
    pulse_pin(3);
    repeat (10) @(posedge core_clk_i);
    #1;
    `CHK(core_clk_en_o, 1'h0)
    `CHK(start_irq_o, 13'h0008)
    @(posedge core_clk_i);
    irq_mask <= 13'h1FFF;
    `WAITC(core_clk_en_o === 1'h1)
    `CHK(core_clk_en_o, 1'h1)
    sleep_cmd <= 1'h0;
    wr(pmu_pkg::ADDR_START_STAT, 32'h0000_1FFF);
    for (int k = 0; k < 2; k++) begin
      wr(pmu_pkg::ADDR_PMODE, k ? 32'h0000_001E : 32'h0000_0006);
      sleep_cmd <= 1'h1;
      `WAITC(core_clk_en_o === 1'h0)
      `CHK({analog_pwr_en_o, wdog_osc_en_o, brownout_detector_en_o}, k ? 3'h3 : 3'h0)
      pulse_pin(5 + k);
      `WAITC(core_clk_en_o === 1'h1)
      `CHK(start_irq_o, 13'(1 << (5 + k)))
      sleep_cmd <= 1'h0;
      wr(pmu_pkg::ADDR_START_STAT, 32'h0000_1FFF);
    end
    for (int k = 0; k < 13; k++) begin
      pulse_pin(k);
      `CHK(start_irq_o, 13'(1 << k))
      wr(pmu_pkg::ADDR_START_STAT, 32'(1 << k));
    end
  endtask : t_sleep

  task automatic t_pd;
    wr(pmu_pkg::ADDR_RESET_STAT, 32'h0000_000F);
    wr(pmu_pkg::ADDR_PMODE, 32'h0000_0007);
    sleep_cmd <= 1'h1;
    `WAITC(core_pwr_en_o === 1'h0)
    `CHK({core_pwr_en_o, core_clk_en_o}, 2'h0)
    deep_power_down_wake_pin_b_i <= 1'h0;
    `WAITC(chip_rst_o === 1'h1)
    `CHK(chip_rst_o, 1'h1)
    @(posedge core_clk_i);
    deep_power_down_wake_pin_b_i <= 1'h1;
    sleep_cmd <= 1'h0;
    `WAITC(chip_rst_o === 1'h0)
    `CHK({core_pwr_en_o, internal_rc_osc_en_o}, 2'h3)
    rd(pmu_pkg::ADDR_RESET_STAT);
    `CHK(rd_val[0], 1'h1)
  endtask : t_pd

  task automatic t_bo;
    for (int k = 0; k < 4; k++) begin
      wr(pmu_pkg::ADDR_BROWNOUT_CFG, 32'(k));
      brownout_below_i <= 4'(1 << k);
      repeat (4) @(posedge core_clk_i);
      #1;
      `CHK(brownout_irq_o, 1'h1)
      rd(pmu_pkg::ADDR_BROWNOUT_STAT);
      `CHK(rd_val[4:0], {1'h1, 4'(1 << k)})
      brownout_below_i <= 4'(1 << ((k + 1) % 4));
      repeat (4) @(posedge core_clk_i);
      #1;
      `CHK(brownout_irq_o, 1'h0)
    end
    for (int k = 0; k < 4; k++) begin
      wr(pmu_pkg::ADDR_BROWNOUT_CFG, 32'((k << 2) | 16));
      brownout_below_i <= 4'(1 << k);
      `WAITC(chip_rst_o === 1'h1)
      `CHK(chip_rst_o, 1'h1)
      @(posedge core_clk_i);
      brownout_below_i <= 4'h0;
      `WAITC(chip_rst_o === 1'h0)
    end
  endtask : t_bo

  initial begin
    t_boot();
    t_src();
    t_sleep();
    t_pd();
    t_bo();
    tally_and_finish();
  end
endmodule : tb
